/* File: design/swp_pkg.sv */
`default_nettype none
// Overview of operation
// - Write data taken with command, then each edge
// - Finished fixed write burst ignores further data
// - Full page burst wraps to column zero
// - New write truncates; its data is its own
// - Read stops all write data from its edge
// - Burst terminate drops data given with it
// - Precharge one bank or all banks
// - Precharged bank idle until activated again
// - Low clock enable with idle nop: power-down
// - Power-down ignores inputs and stops outputs
// - High clock enable with nop ends power-down
// - Low clock enable in burst suspends next edge
// - Suspended edge freezes commands, data and counters
// - High clock enable resumes on next edge
// - Write burst mode bit forces single writes
// - Read cuts auto precharge read, precharge starts
// - Write cuts auto precharge read at once
// - Interrupted auto precharge write recovers, then closes
package swp_pkg;
    localparam int CLK_NS = 20;
    localparam int WR_NS = 15;
    // Extra clock on top of the time, at any rate
    localparam int WR_CYC = 1 + (WR_NS + CLK_NS - 1) / CLK_NS;
    localparam int WRC_W = 3;
    localparam int NBANK = 4;
    localparam int ROW_W = 12;
    localparam int COL_W = 8;
    localparam int DQ_W = 16;
    localparam int DM_W = 2;
    localparam int AP_BIT = 10;
    localparam logic [2:0] C_NOP = 3'h7;
    localparam logic [2:0] C_ACT = 3'h3;
    localparam logic [2:0] C_RD = 3'h5;
    localparam logic [2:0] C_WR = 3'h4;
    localparam logic [2:0] C_BST = 3'h6;
    localparam logic [2:0] C_PRE = 3'h2;
    localparam logic [2:0] BL_FULL = 3'h7;
    localparam logic [1:0] CL_TWO = 2'h2;
    localparam logic RST_CKE = 1'b1;
    typedef enum logic [2:0] {PS_RUN = 3'b001, PS_PDN = 3'b010, PS_SUSP = 3'b100} swp_ps_e;
    typedef enum logic [2:0] {BK_IDLE = 3'b001, BK_RD = 3'b010, BK_WR = 3'b100} swp_bk_e;
    typedef struct packed {logic cs_n; logic ras_n; logic cas_n; logic we_n;} swp_cmd_s;
    typedef struct packed {
        logic [1:0] bank;
        logic [ROW_W-1:0] row;
        logic [COL_W-1:0] col;
    } swp_addr_s;
    typedef struct packed {
        logic en;
        swp_addr_s a;
        logic [DQ_W-1:0] data;
        logic [DM_W-1:0] mask;
    } swp_acc_s;
    typedef struct packed {
        swp_ps_e ps;
        logic cke_q;
        swp_bk_e bk;
        logic ap;
        logic [1:0] bbank;
        logic [COL_W-1:0] scol;
        logic [COL_W-1:0] cnt;
        logic [NBANK-1:0] act;
        logic [NBANK-1:0][ROW_W-1:0] row;
        logic [NBANK-1:0][WRC_W-1:0] wrc;
        logic [1:0] vp;
        logic [DQ_W-1:0] dstage;
        logic [DQ_W-1:0] dq_out;
        logic dq_oe;
        swp_acc_s wr;
        logic rd_en;
        swp_addr_s rd;
    } swp_st_s;
endpackage
`default_nettype wire

/* File: design/swp_sdram_core.sv */
`timescale 1ns/1ps
`default_nettype none
module swp_sdram_core
    import swp_pkg::*;
(
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic cke,
    input wire swp_cmd_s cmd,
    input wire logic [ROW_W-1:0] addr,
    input wire logic [1:0] bank_select,
    input wire logic [DM_W-1:0] dqm,
    input wire logic [DQ_W-1:0] dq_in,
    output logic [DQ_W-1:0] dq_out,
    output logic dq_oe,
    input wire logic [1:0] cas_latency,
    input wire logic [2:0] burst_len,
    input wire logic write_burst_mode_bit,
    output swp_acc_s mem_wr,
    output logic mem_rd_en,
    output swp_addr_s mem_rd,
    input wire logic [DQ_W-1:0] rd_word,
    output logic [NBANK-1:0] bank_active,
    output logic power_down,
    output logic clock_suspended
);
    swp_st_s q;
    swp_st_s d;
    logic [2:0] c;
    logic live;
    logic busy;
    logic full;
    logic [COL_W-1:0] m;
    logic last;
    logic cont;
    logic hit;

    function automatic logic [COL_W-1:0] col_at(
        input logic [COL_W-1:0] s,
        input logic [COL_W-1:0] msk,
        input logic [COL_W-1:0] n
    );
        col_at = (s & ~msk) | (COL_W'(s + n) & msk);
    endfunction

    function automatic logic [COL_W-1:0] len_mask(input logic [2:0] bl);
        case (bl)
            3'h0: len_mask = 8'h00;
            3'h1: len_mask = 8'h01;
            3'h2: len_mask = 8'h03;
            3'h3: len_mask = 8'h07;
            default: len_mask = 8'hFF;
        endcase
    endfunction

    always_comb begin
        d = q;
        d.wr.en = 1'b0;
        d.rd_en = 1'b0;
        c = {cmd.ras_n, cmd.cas_n, cmd.we_n};
        if (cmd.cs_n) begin
            c = C_NOP;
        end
        // Edge is live only if clock enable was high one edge earlier
        live = (q.ps != PS_PDN) && q.cke_q;
        busy = (q.bk != BK_IDLE) || (q.vp != 2'h0) || q.dq_oe;
        full = (burst_len == BL_FULL);
        m = len_mask(burst_len);
        last = !full && (q.cnt == m);
        hit = addr[AP_BIT] || (bank_select == q.bbank);
        cont = (c == C_NOP) || (c == C_ACT) || ((c == C_PRE) && !hit);
        if (q.ps == PS_PDN) begin
            // Only clock enable and a nop command are looked at while powered down
            if (cke && (c == C_NOP)) begin
                d.ps = PS_RUN;
                d.cke_q = 1'b1;
            end
        end else begin
            d.cke_q = cke;
            if (cke) begin
                d.ps = PS_RUN;
            end else if (!busy && (c == C_NOP)) begin
                d.ps = PS_PDN;
            end else begin
                d.ps = PS_SUSP;
            end
            // Nothing below moves on a suspended edge
            if (live) begin
                for (int b = 0; b < NBANK; b++) begin
                    if (q.wrc[b] != '0) begin
                        d.wrc[b] = q.wrc[b] - 1'b1;
                        if (q.wrc[b] == WRC_W'(1)) begin
                            d.act[b] = 1'b0;
                        end
                    end
                end
                d.vp = {q.vp[0], 1'b0};
                d.dstage = rd_word;
                if (cas_latency == CL_TWO) begin
                    d.dq_oe = q.vp[0];
                    d.dq_out = rd_word;
                end else begin
                    d.dq_oe = q.vp[1];
                    d.dq_out = q.dstage;
                end
                if (cont && (q.bk == BK_WR)) begin
                    d.wr.en = 1'b1;
                    d.wr.a.bank = q.bbank;
                    d.wr.a.row = q.row[q.bbank];
                    d.wr.a.col = col_at(q.scol, m, q.cnt);
                    d.wr.data = dq_in;
                    d.wr.mask = dqm;
                    d.cnt = q.cnt + 1'b1;
                    if (last) begin
                        d.bk = BK_IDLE;
                        if (q.ap) begin
                            d.wrc[q.bbank] = WRC_W'(WR_CYC);
                        end
                    end
                end
                if (cont && (q.bk == BK_RD)) begin
                    d.rd_en = 1'b1;
                    d.rd.bank = q.bbank;
                    d.rd.row = q.row[q.bbank];
                    d.rd.col = col_at(q.scol, m, q.cnt);
                    d.vp[0] = 1'b1;
                    d.cnt = q.cnt + 1'b1;
                    if (last) begin
                        d.bk = BK_IDLE;
                        if (q.ap) begin
                            d.act[q.bbank] = 1'b0;
                        end
                    end
                end
                case (c)
                    C_ACT: begin
                        d.act[bank_select] = 1'b1;
                        d.row[bank_select] = addr;
                    end
                    C_PRE: begin
                        if (addr[AP_BIT]) begin
                            d.act = '0;
                            d.wrc = '0;
                        end else begin
                            d.act[bank_select] = 1'b0;
                            d.wrc[bank_select] = '0;
                        end
                        if (hit) begin
                            d.bk = BK_IDLE;
                        end
                    end
                    C_BST: begin
                        d.bk = BK_IDLE;
                    end
                    C_RD, C_WR: begin
                        if ((q.bk != BK_IDLE) && q.ap && (bank_select != q.bbank)) begin
                            if (q.bk == BK_RD) begin
                                d.act[q.bbank] = 1'b0;
                            end else begin
                                d.wrc[q.bbank] = WRC_W'(WR_CYC);
                            end
                        end
                        d.bbank = bank_select;
                        d.scol = addr[COL_W-1:0];
                        d.ap = addr[AP_BIT];
                        d.cnt = 8'h01;
                        if (c == C_RD) begin
                            // Pending write data is dropped here
                            d.bk = (m == 8'h00 && !full) ? BK_IDLE : BK_RD;
                            d.rd_en = 1'b1;
                            d.rd.bank = bank_select;
                            d.rd.row = q.row[bank_select];
                            d.rd.col = addr[COL_W-1:0];
                            d.vp[0] = 1'b1;
                            if ((d.bk == BK_IDLE) && addr[AP_BIT]) begin
                                d.act[bank_select] = 1'b0;
                            end
                        end else begin
                            // Write frees the bus at once
                            d.vp = 2'h0;
                            d.dq_oe = 1'b0;
                            d.wr.en = 1'b1;
                            d.wr.a.bank = bank_select;
                            d.wr.a.row = q.row[bank_select];
                            d.wr.a.col = addr[COL_W-1:0];
                            d.wr.data = dq_in;
                            d.wr.mask = dqm;
                            if (write_burst_mode_bit || (m == 8'h00 && !full)) begin
                                d.bk = BK_IDLE;
                                if (addr[AP_BIT]) begin
                                    d.wrc[bank_select] = WRC_W'(WR_CYC);
                                end
                            end else begin
                                d.bk = BK_WR;
                            end
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            q <= '0;
            q.ps <= PS_RUN;
            q.bk <= BK_IDLE;
            q.cke_q <= RST_CKE;
        end else begin
            q <= d;
        end
    end

    assign dq_out = q.dq_out;
    assign dq_oe = q.dq_oe;
    assign mem_wr = q.wr;
    assign mem_rd_en = q.rd_en;
    assign mem_rd = q.rd;
    assign bank_active = q.act;
    // One-hot state bits, so both flags come straight from a flip-flop
    assign power_down = q.ps[1];
    assign clock_suspended = q.ps[2];

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (srst);

    wr_capture_a: assert property (
        live && c == C_WR |=> q.wr.en && q.wr.data == $past(dq_in) && q.wr.a.col == $past(addr[7:0])
    ) else $error("write data not taken with command");
    burst_done_a: assert property (
        live && q.bk == BK_IDLE && c == C_NOP |=> !q.wr.en
    ) else $error("write after burst end");
    rd_block_a: assert property (
        live && c == C_RD |=> !q.wr.en ##1 (q.bk != BK_WR)
    ) else $error("write kept after read");
    bst_drop_a: assert property (
        live && c == C_BST |=> !q.wr.en && q.bk == BK_IDLE
    ) else $error("data taken with burst terminate");
    pre_all_a: assert property (
        live && c == C_PRE && addr[AP_BIT] |=> q.act == '0
    ) else $error("precharge all left a bank open");
    pdn_enter_a: assert property (
        q.ps == PS_RUN && !cke && c == C_NOP && !busy |=> q.ps == PS_PDN
    ) else $error("power-down not entered");
    pdn_quiet_a: assert property (
        q.ps == PS_PDN |=> !q.dq_oe && !q.wr.en && !q.rd_en
    ) else $error("activity in power-down");
    pdn_exit_a: assert property (
        q.ps == PS_PDN && cke && c == C_NOP |=> q.ps == PS_RUN && q.cke_q
    ) else $error("power-down not left");
    susp_hold_a: assert property (
        q.ps != PS_PDN && !q.cke_q |=> $stable(q.cnt) && $stable(q.dq_out) && !q.wr.en
    ) else $error("suspended edge moved state");
    single_wr_a: assert property (
        live && c == C_WR && write_burst_mode_bit
        |=> q.bk == BK_IDLE ##1 (!q.wr.en || $past(c == C_WR))
    ) else $error("burst write in single write mode");
    rd_ap_cut_a: assert property (
        live && c == C_RD && q.bk == BK_RD && q.ap && bank_select != q.bbank
        |=> !q.act[$past(q.bbank)]
    ) else $error("auto precharge read bank still open");
    wr_ap_wait_a: assert property (
        live && c == C_WR && q.bk == BK_WR && q.ap && bank_select != q.bbank
        |=> q.act[$past(q.bbank)] && q.wrc[$past(q.bbank)] == WRC_W'(WR_CYC)
    ) else $error("auto precharge write recovery not started");

    wr_wr_c: cover property (live && c == C_WR ##1 live && c == C_WR);
    pdn_c: cover property (q.ps == PS_PDN ##1 q.ps == PS_RUN);
    susp_wr_c: cover property (q.bk == BK_WR && q.ps == PS_SUSP);
    wrap_c: cover property (q.bk == BK_WR && q.cnt == 8'hFF);
endmodule // swp_sdram_core
`default_nettype wire

/* File: dv/sdram_write_precharge_power_ctrl_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module sdram_write_precharge_power_ctrl_tb;
    import swp_pkg::*;
    typedef struct packed {
        logic [2:0] op;
        logic [11:0] a;
        logic [15:0] d;
        logic en;
        logic [7:0] col;
        logic [3:0] act;
    } swp_row_s;
    // Bank 0, burst of four; expected write word is the row's own data
    localparam swp_row_s ROWS [16] = '{
        '{C_ACT, 12'h012, 16'h0000, 1'b0, 8'h00, 4'h1},
        '{C_NOP, 12'h000, 16'h0000, 1'b0, 8'h00, 4'h1},
        '{C_NOP, 12'h000, 16'h0000, 1'b0, 8'h00, 4'h1},
        '{C_WR, 12'h005, 16'h1111, 1'b1, 8'h05, 4'h1},
        '{C_NOP, 12'h000, 16'h2222, 1'b1, 8'h06, 4'h1},
        '{C_NOP, 12'h000, 16'h3333, 1'b1, 8'h07, 4'h1},
        '{C_NOP, 12'h000, 16'h4444, 1'b1, 8'h04, 4'h1},
        '{C_NOP, 12'h000, 16'h5555, 1'b0, 8'h00, 4'h1},
        '{C_WR, 12'h010, 16'hAAAA, 1'b1, 8'h10, 4'h1},
        '{C_WR, 12'h020, 16'hBBBB, 1'b1, 8'h20, 4'h1},
        '{C_NOP, 12'h000, 16'hCCCC, 1'b1, 8'h21, 4'h1},
        '{C_BST, 12'h000, 16'hDDDD, 1'b0, 8'h00, 4'h1},
        '{C_WR, 12'h030, 16'hEEEE, 1'b1, 8'h30, 4'h1},
        '{C_RD, 12'h030, 16'hFFFF, 1'b0, 8'h00, 4'h1},
        '{C_NOP, 12'h000, 16'h0000, 1'b0, 8'h00, 4'h1},
        '{C_PRE, 12'h000, 16'h0000, 1'b0, 8'h00, 4'h0}
    };
    logic sys_clk = 1'b0;
    logic srst = 1'b1;
    logic [2:0] burst_len = 3'h2;
    logic write_burst_mode_bit = 1'b0;
    logic cke;
    swp_cmd_s cmd;
    logic [ROW_W-1:0] addr;
    logic [1:0] bank_select;
    logic [DM_W-1:0] dqm;
    logic [DQ_W-1:0] dq_in;
    logic [DQ_W-1:0] dq_out;
    logic dq_oe;
    swp_acc_s mem_wr;
    logic mem_rd_en;
    swp_addr_s mem_rd;
    logic [DQ_W-1:0] rd_word;
    logic [NBANK-1:0] bank_active;
    logic power_down;
    logic clock_suspended;
    int fails = 0;
    int check_count = 0;
    always #10 sys_clk = ~sys_clk;
    swp_sdram_core i_dut (.sys_clk(sys_clk), .srst(srst), .cke(cke), .cmd(cmd), .addr(addr),
        .bank_select(bank_select), .dqm(dqm), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
        .cas_latency(CL_TWO), .burst_len(burst_len),
        .write_burst_mode_bit(write_burst_mode_bit), .mem_wr(mem_wr), .mem_rd_en(mem_rd_en),
        .mem_rd(mem_rd), .rd_word(rd_word), .bank_active(bank_active),
        .power_down(power_down), .clock_suspended(clock_suspended));
    swp_ctrl_model i_ctrl (.sys_clk(sys_clk), .cke(cke), .cmd(cmd), .addr(addr),
        .bank_select(bank_select), .dqm(dqm), .dq_in(dq_in), .mem_rd(mem_rd),
        .rd_word(rd_word));
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        check_count++;
        if (g !== e) begin
            $display("wrong value %s expected %h seen %h", n, e, g);
            fails++;
        end
    endtask
    // One command cycle, then the write strobe it should give
    task automatic gw(input logic c, input logic [2:0] op, input logic [11:0] a,
        input logic [1:0] b, input logic [15:0] d, input logic en, input logic [7:0] col);
        i_ctrl.step(c, op, a, b, d);
        chk("write strobe", 16'(en), 16'(mem_wr.en));
        if (en) begin
            chk("write column", 16'(col), 16'(mem_wr.a.col));
            chk("write data", d, mem_wr.data);
            chk("write bank", 16'(b), 16'(mem_wr.a.bank));
        end
    endtask
    task automatic do_reset(input logic [2:0] bl, input logic wb);
        srst = 1'b1;
        burst_len = bl;
        write_burst_mode_bit = wb;
        repeat (12) @(negedge sys_clk);
        srst = 1'b0;
        chk("power down", 16'h0000, 16'(power_down));
        chk("open banks", 16'h0000, 16'(bank_active));
        chk("write strobe", 16'h0000, 16'(mem_wr.en));
    endtask
    // Tests need under a hundred cycles; twenty times that is a hang
    initial begin
        repeat (2000) @(posedge sys_clk);
        fails++;
        print_verdict();
    end
    initial begin
        do_reset(3'h2, 1'b0);
        foreach (ROWS[i]) begin
            gw(1'b1, ROWS[i].op, ROWS[i].a, 2'h0, ROWS[i].d, ROWS[i].en, ROWS[i].col);
            chk("open banks", 16'(ROWS[i].act), 16'(bank_active));
        end
        do_reset(BL_FULL, 1'b0);
        i_ctrl.open_row(2'h1, 12'h0AB);
        gw(1'b1, C_WR, 12'h0FE, 2'h1, 16'h0001, 1'b1, 8'hFE);
        gw(1'b1, C_NOP, 12'h000, 2'h1, 16'h0002, 1'b1, 8'hFF);
        gw(1'b1, C_NOP, 12'h000, 2'h1, 16'h0003, 1'b1, 8'h00);
        gw(1'b1, C_BST, 12'h000, 2'h1, 16'h0004, 1'b0, 8'h00);
        i_ctrl.open_row(2'h2, 12'h003);
        chk("open banks", 16'h0006, 16'(bank_active));
        gw(1'b1, C_PRE, 12'h400, 2'h3, 16'h0000, 1'b0, 8'h00);
        chk("open banks", 16'h0000, 16'(bank_active));
        gw(1'b0, C_NOP, 12'h000, 2'h0, 16'h0000, 1'b0, 8'h00);
        chk("power down", 16'h0001, 16'(power_down));
        gw(1'b0, C_ACT, 12'h001, 2'h0, 16'h0000, 1'b0, 8'h00);
        chk("open banks", 16'h0000, 16'(bank_active));
        // Brief stay, far inside the refresh period
        gw(1'b1, C_NOP, 12'h000, 2'h0, 16'h0000, 1'b0, 8'h00);
        chk("power down", 16'h0000, 16'(power_down));
        i_ctrl.open_row(2'h0, 12'h001);
        chk("open banks", 16'h0001, 16'(bank_active));
        gw(1'b1, C_WR, 12'h010, 2'h0, 16'h00A0, 1'b1, 8'h10);
        gw(1'b0, C_NOP, 12'h000, 2'h0, 16'h00A1, 1'b1, 8'h11);
        chk("suspended", 16'h0001, 16'(clock_suspended));
        // Terminate on the frozen edge must be lost as well
        gw(1'b1, C_BST, 12'h000, 2'h0, 16'h00A9, 1'b0, 8'h00);
        gw(1'b1, C_NOP, 12'h000, 2'h0, 16'h00A2, 1'b1, 8'h12);
        gw(1'b1, C_BST, 12'h000, 2'h0, 16'h00A3, 1'b0, 8'h00);
        // Truncating precharge: mask the edge before it and its own edge
        gw(1'b1, C_WR, 12'h020, 2'h0, 16'h00B0, 1'b1, 8'h20);
        i_ctrl.mask(2'h3);
        gw(1'b1, C_NOP, 12'h000, 2'h0, 16'h00B1, 1'b1, 8'h21);
        chk("write mask", 16'h0003, 16'(mem_wr.mask));
        gw(1'b1, C_PRE, 12'h000, 2'h0, 16'h00B2, 1'b0, 8'h00);
        chk("open banks", 16'h0000, 16'(bank_active));
        i_ctrl.mask(2'h0);
        do_reset(3'h2, 1'b1);
        i_ctrl.open_row(2'h3, 12'h005);
        gw(1'b1, C_WR, 12'h008, 2'h3, 16'h1234, 1'b1, 8'h08);
        gw(1'b1, C_NOP, 12'h000, 2'h3, 16'h5678, 1'b0, 8'h00);
        gw(1'b1, C_RD, 12'h004, 2'h3, 16'h0000, 1'b0, 8'h00);
        gw(1'b1, C_NOP, 12'h000, 2'h3, 16'h0000, 1'b0, 8'h00);
        chk("read drive", 16'h0001, 16'(dq_oe));
        chk("read data", 16'h04FB, dq_out);
        gw(1'b1, C_NOP, 12'h000, 2'h3, 16'h0000, 1'b0, 8'h00);
        chk("read data", 16'h05FA, dq_out);
        // Auto precharge write cuts the read; bank closes after recovery
        gw(1'b1, C_WR, 12'h40C, 2'h3, 16'h9999, 1'b1, 8'h0C);
        chk("read drive", 16'h0000, 16'(dq_oe));
        gw(1'b1, C_NOP, 12'h000, 2'h3, 16'h0000, 1'b0, 8'h00);
        chk("open banks", 16'h0008, 16'(bank_active));
        gw(1'b1, C_NOP, 12'h000, 2'h3, 16'h0000, 1'b0, 8'h00);
        chk("open banks", 16'h0000, 16'(bank_active));
        print_verdict();
    end
endmodule // sdram_write_precharge_power_ctrl_tb
`default_nettype wire

/* File: dv/swp_ctrl_model.sv */
`timescale 1ns/1ps
`default_nettype none
module swp_ctrl_model
    import swp_pkg::*;
(
    input wire logic sys_clk,
    output logic cke,
    output swp_cmd_s cmd,
    output logic [ROW_W-1:0] addr,
    output logic [1:0] bank_select,
    output logic [DM_W-1:0] dqm,
    output logic [DQ_W-1:0] dq_in,
    input wire swp_addr_s mem_rd,
    output logic [DQ_W-1:0] rd_word
);
    // Column and its inverse, so a wrong column shows in both bytes
    assign rd_word = {mem_rd.col, ~mem_rd.col};
    initial begin
        cke = 1'b1;
        cmd = {1'b0, C_NOP};
        addr = '0;
        bank_select = '0;
        dqm = '0;
        dq_in = 16'hA5A5;
    end
    // Entered at a falling edge, returns at the falling edge after the taking edge
    task automatic step(input logic c, input logic [2:0] op, input logic [ROW_W-1:0] a,
        input logic [1:0] b, input logic [DQ_W-1:0] d);
        cke = c; // Half a period of setup before the edge
        cmd = {1'b0, op};
        addr = a;
        bank_select = b;
        dq_in = d; // Word travels with its own command
        @(posedge sys_clk);
        @(negedge sys_clk);
    endtask
    // Byte mask, changed between edges like the other pins
    task automatic mask(input logic [DM_W-1:0] mv);
        dqm = mv;
    endtask
    // Row opened, then the column delay waited in whole clocks
    task automatic open_row(input logic [1:0] b, input logic [ROW_W-1:0] r);
        step(1'b1, C_ACT, r, b, ~dq_in);
        repeat (2) step(1'b1, C_NOP, '0, b, ~dq_in);
    endtask
endmodule // swp_ctrl_model
`default_nettype wire
